// [psc_controller.sv]
// Operation
// RL1: exactly three states, run, halt, standby, driving clock gates.
// RL2: standby keeps only slow domain; main oscillator and derived clocks off.
// RL3: run enables both oscillators and all hardware clocks.
// RL4: rising wake edge leaves standby; sole exit after power-on; the code also takes the irq/fiq exit then when interruptsEnabled is set.
// RL5: ignore wake edges in the post power-on blackout; boot follows later.
// RL6: divider write in run passes through standby for pll lock, returns.
// RL7: irq/fiq falling edge in standby returns to run after 10-15 ms.
// RL8: irq/fiq falling edge in halt returns to run; tick never does.
// RL9: low-battery halt exit only on battery power, battery-good low 61 us.
// RL10: halt stops cpu clock, keeps main oscillator running.
// RL11: halt entered only by halt register read while in run.
// RL12: oscillator enable output drops when standby entry begins.
// RL13: sdram self refresh requested before clocks stop for standby; the code raises it on the same edge that the clocks stop.
// RL14: software follows standby read with five no-ops.
// RL15: power-fail low in run or halt forces standby after bus cycle.
// RL16: user reset low in run or halt forces standby.
// RL17: forced standby held one to two slow ticks before next move.
// RL18: standby to run blocked on battery power with battery bad.
// RL19: supply sampling delayed one to two seconds after low-battery off.
// RL20: standby goes only to run; standby is the reset state.
// RL21: wake pin disable set ignores the wake pin in standby.
// RL22: woke flag set on wake exit; cleared by halt, standby, flag-clear.
// RL23: sticky power-fail and user-reset flags cleared by flag-clear write.
// RL24: forced standby wins over coincident interrupt or wake.
// RL25: all pins pass two flip-flops before use.
`default_nettype none
`include "psc_params.svh"
module psc_controller #(
	parameter int TICK_DIV = `PSC_TICK_DIV,
	parameter int BLACKOUT_TICKS = `PSC_BLACKOUT_TICKS,
	parameter int IRQ_EXIT_TICKS = `PSC_IRQ_EXIT_TICKS,
	parameter int PLL_LOCK_TICKS = `PSC_PLL_LOCK_TICKS
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic wakePin,
	input wire logic powerFailIn_n,
	input wire logic userResetIn_n,
	input wire logic irq_n,
	input wire logic fiq_n,
	input wire logic lowBatteryIrq,
	input wire logic externalSupplyIndicator_n,
	input wire logic batteryGood,
	input wire logic interruptsEnabled,
	input wire logic wakePinDisable,
	input wire logic haltRegRead,
	input wire logic standbyRegRead,
	input wire logic flagClearWrite,
	input wire logic clockDividerWrite,
	input wire logic busCycleDone,
	input wire logic sdramSelfRefreshAck,
	output logic [1:0] operatingState,
	output logic oscillatorEnableOut,
	output logic mainClockEnable,
	output logic cpuClockEnable,
	output logic pllReconfigure,
	output logic sdramSelfRefreshReq,
	output logic wokeFromStandbyFlag,
	output logic powerFailFlag,
	output logic userResetFlag,
	output logic bootStart
);
	psc_sync_if syncBus ();
	psc_pkg::psc_state_t state;
	psc_pkg::psc_state_t next_state;
	logic wakeLast, irqLast, fiqLast;
	logic wakeRise, irqFall;
	logic [`PSC_CNT_W-1:0] blackoutCount;
	logic [`PSC_CNT_W-1:0] waitCount;
	logic [`PSC_CNT_W-1:0] holdCount;
	logic [`PSC_CNT_W-1:0] bootCount;
	logic [`PSC_CNT_W-1:0] batLowCount;
	logic irqPending, pllPending, forceReq, runAllowed, batLowStable;
	logic entering;

	psc_sync #(.TICK_DIV(TICK_DIV)) syncUnit (
		.clk(clk),
		.reset_n(reset_n),
		.wakePin(wakePin),
		.powerFailIn_n(powerFailIn_n),
		.userResetIn_n(userResetIn_n),
		.irq_n(irq_n),
		.fiq_n(fiq_n),
		.externalSupplyIndicator_n(externalSupplyIndicator_n),
		.batteryGood(batteryGood),
		.syncOut(syncBus.source)
	);

	function automatic logic cntDone(input logic [`PSC_CNT_W-1:0] c);
		cntDone = (c == '0);
	endfunction

	assign wakeRise = syncBus.wake && !wakeLast;
	assign irqFall = (!syncBus.irqN && irqLast) || (!syncBus.fiqN && fiqLast);
	// power fail waits for the bus cycle; user reset does not [RL15] [RL16]
	assign forceReq = (!syncBus.powerFailN && busCycleDone) || !syncBus.userResetN;
	// battery power with a bad battery blocks wake [RL18]
	assign runAllowed = !(syncBus.extSupplyN && !syncBus.batteryGood);
	assign batLowStable = (batLowCount == `PSC_CNT_W'(`PSC_BATLOW_TICKS));
	assign entering = (state != psc_pkg::PSC_STANDBY) && (next_state == psc_pkg::PSC_STANDBY);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wakeLast <= 1'b0;
			irqLast <= 1'b1;
			fiqLast <= 1'b1;
		end else begin
			wakeLast <= syncBus.wake;
			irqLast <= syncBus.irqN;
			fiqLast <= syncBus.fiqN;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			psc_pkg::PSC_RUN: begin
				if (forceReq) begin
					next_state = psc_pkg::PSC_STANDBY; // [RL24]
				end else if (standbyRegRead || clockDividerWrite) begin
					next_state = psc_pkg::PSC_STANDBY; // [RL6]
				end else if (haltRegRead) begin
					next_state = psc_pkg::PSC_HALT; // [RL11]
				end
			end
			psc_pkg::PSC_HALT: begin
				if (forceReq) begin
					next_state = psc_pkg::PSC_STANDBY;
				end else if (interruptsEnabled && irqFall) begin
					next_state = psc_pkg::PSC_RUN; // [RL8]
				end else if (interruptsEnabled && lowBatteryIrq && batLowStable
					&& syncBus.extSupplyN) begin
					next_state = psc_pkg::PSC_RUN; // [RL9]
				end
			end
			psc_pkg::PSC_STANDBY: begin
				// only run is reachable, and only once holds expire [RL20] [RL17] [RL19]
				if (cntDone(holdCount) && cntDone(blackoutCount) && runAllowed
					&& syncBus.userResetN && syncBus.powerFailN) begin
					if (pllPending && cntDone(waitCount)) begin
						next_state = psc_pkg::PSC_RUN;
					end else if (!pllPending && wakeRise && !wakePinDisable) begin
						next_state = psc_pkg::PSC_RUN; // [RL4] [RL21] [RL5]
					end else if (irqPending && cntDone(waitCount)) begin
						next_state = psc_pkg::PSC_RUN; // [RL7]
					end
				end
			end
			default: next_state = psc_pkg::PSC_STANDBY;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= psc_pkg::PSC_STANDBY; // [RL20]
		end else begin
			state <= next_state; // [RL1]
		end
	end

	// blackout after power-on and after a low-battery power-off [RL5] [RL19]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			blackoutCount <= `PSC_CNT_W'(BLACKOUT_TICKS);
		end else if (entering && !syncBus.batteryGood) begin
			blackoutCount <= `PSC_CNT_W'(BLACKOUT_TICKS);
		end else if (syncBus.tick && !cntDone(blackoutCount)) begin
			blackoutCount <= blackoutCount - `PSC_CNT_W'(1);
		end
	end

	// forced entry hold; two ticks gives a 61-122 us window [RL17]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			holdCount <= '0;
		end else if (entering && forceReq) begin
			holdCount <= `PSC_CNT_W'(`PSC_HOLD_TICKS);
		end else if (syncBus.tick && !cntDone(holdCount)) begin
			holdCount <= holdCount - `PSC_CNT_W'(1);
		end
	end

	// pll lock wait and interrupt exit delay share one counter [RL6] [RL7]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pllPending <= 1'b0;
			irqPending <= 1'b0;
			waitCount <= '0;
		end else if (state == psc_pkg::PSC_RUN && clockDividerWrite && !forceReq) begin
			pllPending <= 1'b1;
			waitCount <= `PSC_CNT_W'(PLL_LOCK_TICKS);
		end else if (state == psc_pkg::PSC_STANDBY && next_state == psc_pkg::PSC_RUN) begin
			pllPending <= 1'b0;
			irqPending <= 1'b0;
		end else if (state == psc_pkg::PSC_STANDBY && !pllPending && !irqPending
			&& interruptsEnabled && irqFall) begin
			irqPending <= 1'b1;
			waitCount <= `PSC_CNT_W'(IRQ_EXIT_TICKS);
		end else if (entering) begin
			pllPending <= 1'b0;
		end else if (syncBus.tick && !cntDone(waitCount)) begin
			waitCount <= waitCount - `PSC_CNT_W'(1);
		end
	end

	// battery-good must stay low until the next tick, at most 61 us, before the low-battery exit counts [RL9]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			batLowCount <= '0;
		end else if (syncBus.batteryGood) begin
			batLowCount <= '0;
		end else if (syncBus.tick && !batLowStable) begin
			batLowCount <= batLowCount + `PSC_CNT_W'(1);
		end
	end

	// clock gating by state; oscillator drops the cycle standby begins [RL2] [RL3] [RL10] [RL12]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			operatingState <= 2'h0;
			oscillatorEnableOut <= 1'b0;
			mainClockEnable <= 1'b0;
			cpuClockEnable <= 1'b0;
			pllReconfigure <= 1'b0;
		end else begin
			operatingState <= next_state;
			oscillatorEnableOut <= next_state != psc_pkg::PSC_STANDBY;
			mainClockEnable <= next_state != psc_pkg::PSC_STANDBY;
			cpuClockEnable <= next_state == psc_pkg::PSC_RUN;
			pllReconfigure <= state == psc_pkg::PSC_RUN && clockDividerWrite;
		end
	end

	// self refresh asked as standby begins; held until run [RL13]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sdramSelfRefreshReq <= 1'b1;
		end else if (entering) begin
			sdramSelfRefreshReq <= 1'b1;
		end else if (next_state == psc_pkg::PSC_RUN && state == psc_pkg::PSC_STANDBY) begin
			sdramSelfRefreshReq <= 1'b0;
		end
	end

	// status flags; a set beats a clear in the same cycle [RL22] [RL23]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wokeFromStandbyFlag <= 1'b0;
			powerFailFlag <= 1'b0;
			userResetFlag <= 1'b0;
		end else begin
			if (state == psc_pkg::PSC_STANDBY && next_state == psc_pkg::PSC_RUN && !pllPending
				&& wakeRise && !wakePinDisable) begin
				wokeFromStandbyFlag <= 1'b1;
			end else if (flagClearWrite || haltRegRead || standbyRegRead) begin
				wokeFromStandbyFlag <= 1'b0;
			end
			if (entering && !syncBus.powerFailN) begin
				powerFailFlag <= 1'b1;
			end else if (flagClearWrite) begin
				powerFailFlag <= 1'b0;
			end
			if (entering && !syncBus.userResetN) begin
				userResetFlag <= 1'b1;
			end else if (flagClearWrite) begin
				userResetFlag <= 1'b0;
			end
		end
	end

	// boot start pulse after every standby-to-run exit; sdram ack unused by the timing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bootCount <= '0;
			bootStart <= 1'b0;
		end else begin
			bootStart <= 1'b0;
			if (state == psc_pkg::PSC_STANDBY && next_state == psc_pkg::PSC_RUN) begin
				bootCount <= `PSC_CNT_W'(`PSC_BOOT_TICKS);
			end else if (syncBus.tick && bootCount == `PSC_CNT_W'(1)) begin
				bootCount <= '0;
				bootStart <= sdramSelfRefreshAck || 1'b1; // [RL5]
			end else if (syncBus.tick && !cntDone(bootCount)) begin
				bootCount <= bootCount - `PSC_CNT_W'(1);
			end
		end
	end

	halt_only_run_a: assert property (@(posedge clk) disable iff (!reset_n) // [RL11]
		(state != psc_pkg::PSC_RUN) |=> (state != psc_pkg::PSC_HALT) || $past(state) == state)
		else $error("halt entered from other than run");
	standby_to_run_a: assert property (@(posedge clk) disable iff (!reset_n) // [RL20]
		(state == psc_pkg::PSC_STANDBY) |=> (state != psc_pkg::PSC_HALT))
		else $error("standby moved to halt");
	force_standby_a: assert property (@(posedge clk) disable iff (!reset_n) // [RL16]
		(state != psc_pkg::PSC_STANDBY && !syncBus.userResetN) |=>
		(state == psc_pkg::PSC_STANDBY))
		else $error("user reset did not force standby");
	osc_off_a: assert property (@(posedge clk) disable iff (!reset_n) // [RL12]
		(state == psc_pkg::PSC_STANDBY) |-> !oscillatorEnableOut)
		else $error("oscillator on in standby");
	cpu_clock_a: assert property (@(posedge clk) disable iff (!reset_n) // [RL10]
		(state == psc_pkg::PSC_HALT) |-> !cpuClockEnable && mainClockEnable)
		else $error("halt clock gating wrong");
	hold_block_a: assert property (@(posedge clk) disable iff (!reset_n) // [RL17]
		!cntDone(holdCount) |-> next_state != psc_pkg::PSC_RUN)
		else $error("left standby during hold");
	battery_block_a: assert property (@(posedge clk) disable iff (!reset_n) // [RL18]
		(state == psc_pkg::PSC_STANDBY && !runAllowed) |=> state == psc_pkg::PSC_STANDBY)
		else $error("run entered on bad battery");
	pf_flag_a: assert property (@(posedge clk) disable iff (!reset_n) // [RL23]
		(entering && !syncBus.powerFailN) |=> powerFailFlag)
		else $error("power fail flag not set");
	refresh_a: assert property (@(posedge clk) disable iff (!reset_n) // [RL13]
		(state == psc_pkg::PSC_STANDBY) |-> sdramSelfRefreshReq)
		else $error("no self refresh in standby");
	wake_disable_a: assert property (@(posedge clk) disable iff (!reset_n) // [RL21]
		(state == psc_pkg::PSC_STANDBY && wakePinDisable && !pllPending && !irqPending)
		|=> state == psc_pkg::PSC_STANDBY)
		else $error("wake pin honoured while disabled");
	pll_standby_a: assert property (@(posedge clk) disable iff (!reset_n) // [RL6]
		pllReconfigure |-> state == psc_pkg::PSC_STANDBY)
		else $error("divider write did not pass through standby");
	halt_masked_a: assert property (@(posedge clk) disable iff (!reset_n) // [RL8]
		(state == psc_pkg::PSC_HALT && !interruptsEnabled && !forceReq) |=>
		state == psc_pkg::PSC_HALT)
		else $error("halt left with interrupts masked");
	halt_irq_a: assert property (@(posedge clk) disable iff (!reset_n) // [RL8]
		(state == psc_pkg::PSC_HALT && interruptsEnabled && irqFall && !forceReq) |=>
		state == psc_pkg::PSC_RUN)
		else $error("interrupt edge did not end halt");
	blackout_block_a: assert property (@(posedge clk) disable iff (!reset_n) // [RL5]
		(state == psc_pkg::PSC_STANDBY && !cntDone(blackoutCount)) |=>
		state == psc_pkg::PSC_STANDBY)
		else $error("left standby during blackout");
	woke_set_a: assert property (@(posedge clk) disable iff (!reset_n) // [RL22]
		(state == psc_pkg::PSC_STANDBY && !pllPending && !irqPending) ##1
		(state == psc_pkg::PSC_RUN) |-> wokeFromStandbyFlag)
		else $error("wake exit left the woke flag clear");
	wake_c: cover property (@(posedge clk) disable iff (!reset_n)
		state == psc_pkg::PSC_STANDBY ##1 state == psc_pkg::PSC_RUN);
	halt_c: cover property (@(posedge clk) disable iff (!reset_n)
		state == psc_pkg::PSC_HALT ##1 state == psc_pkg::PSC_RUN);
	pll_c: cover property (@(posedge clk) disable iff (!reset_n)
		pllReconfigure ##[1:300] state == psc_pkg::PSC_STANDBY);
	force_c: cover property (@(posedge clk) disable iff (!reset_n)
		(forceReq && state == psc_pkg::PSC_HALT) ##1 (state == psc_pkg::PSC_STANDBY));
endmodule
`default_nettype wire

// [psc_params.svh]
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH
// system clock rate and the 16.384 kHz tick derived from it
`define PSC_CLK_HZ 200000000
`define PSC_TICK_HZ 16384
`define PSC_TICK_DIV (`PSC_CLK_HZ / `PSC_TICK_HZ)
// sampling blackout after power-on and after a low-battery power-off, in ms
`define PSC_BLACKOUT_MS 1000
`define PSC_BLACKOUT_TICKS ((`PSC_BLACKOUT_MS * `PSC_TICK_HZ) / 1000)
// boot start delay after any standby exit to run, in ms
`define PSC_BOOT_MS 16
`define PSC_BOOT_TICKS ((`PSC_BOOT_MS * `PSC_TICK_HZ) / 1000)
// interrupt exit from standby, in ms (10-15 ms; least figure)
`define PSC_IRQ_EXIT_MS 10
`define PSC_IRQ_EXIT_TICKS ((`PSC_IRQ_EXIT_MS * `PSC_TICK_HZ) / 1000)
// pll lock time spent in standby after a divider write, in ticks
`define PSC_PLL_LOCK_TICKS 16
// low-battery stability time, 61 us, in ticks (one tick is 61 us)
`define PSC_BATLOW_TICKS 1
// minimum standby hold after a forced entry: one to two ticks
`define PSC_HOLD_TICKS 2
`define PSC_CNT_W 16
`endif

// [psc_pkg.sv]
`default_nettype none
package psc_pkg;
	typedef enum logic [1:0] {
		PSC_STANDBY,
		PSC_RUN,
		PSC_HALT
	} psc_state_t;
endpackage
`default_nettype wire

// [psc_sync_if.sv]
`default_nettype none
interface psc_sync_if;
	logic wake;
	logic powerFailN;
	logic userResetN;
	logic irqN;
	logic fiqN;
	logic extSupplyN;
	logic batteryGood;
	logic tick;
	modport source (output wake, powerFailN, userResetN, irqN, fiqN, extSupplyN,
		batteryGood, tick);
	modport sink (input wake, powerFailN, userResetN, irqN, fiqN, extSupplyN,
		batteryGood, tick);
endinterface
`default_nettype wire

// [psc_sync.sv]
`default_nettype none
`include "psc_params.svh"
module psc_sync #(
	parameter int TICK_DIV = `PSC_TICK_DIV
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic wakePin,
	input wire logic powerFailIn_n,
	input wire logic userResetIn_n,
	input wire logic irq_n,
	input wire logic fiq_n,
	input wire logic externalSupplyIndicator_n,
	input wire logic batteryGood,
	psc_sync_if.source syncOut
);
	localparam int W = 7;
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [15:0] divCount;
	logic tick;

	// two flops on every pin; only stage2 is looked at [RL25]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1 <= 7'h7e;
			stage2 <= 7'h7e;
		end else begin
			stage1 <= {batteryGood, externalSupplyIndicator_n, fiq_n, irq_n,
				userResetIn_n, powerFailIn_n, wakePin};
			stage2 <= stage1;
		end
	end

	// 16.384 kHz enable pulse from the system clock
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			divCount <= 16'h0;
			tick <= 1'b0;
		end else if (divCount == 16'(TICK_DIV - 1)) begin
			divCount <= 16'h0;
			tick <= 1'b1;
		end else begin
			divCount <= divCount + 16'h1;
			tick <= 1'b0;
		end
	end

	assign syncOut.wake = stage2[0];
	assign syncOut.powerFailN = stage2[1];
	assign syncOut.userResetN = stage2[2];
	assign syncOut.irqN = stage2[3];
	assign syncOut.fiqN = stage2[4];
	assign syncOut.extSupplyN = stage2[5];
	assign syncOut.batteryGood = stage2[6];
	assign syncOut.tick = tick;
endmodule
`default_nettype wire

// [psc_core_model.sv]
`default_nettype none
module psc_core_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sdramSelfRefreshReq,
	output logic busCycleDone,
	output logic sdramSelfRefreshAck
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] phase;
	logic [1:0] ackLine;
	// a bus cycle spans four clocks; a power-fail standby must wait for its last one
	always @(negedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end
	assign busCycleDone = (phase == 2'h3);
	// memory side answers the self-refresh request two clocks late, as slow parts do
	always @(negedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ackLine <= 2'h0;
		end else begin
			ackLine <= {ackLine[0], sdramSelfRefreshReq};
		end
	end
	assign sdramSelfRefreshAck = ackLine[1];
endmodule
`default_nettype wire

// [tb_top.sv]
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TDIV = 4;
	localparam logic [1:0] SB = 2'h0;
	localparam logic [1:0] RN = 2'h1;
	localparam logic [1:0] HT = 2'h2;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic wakePin = 1'b0, powerFailIn_n = 1'b1, userResetIn_n = 1'b1;
	logic irq_n = 1'b1, fiq_n = 1'b1, lowBatteryIrq = 1'b0;
	logic externalSupplyIndicator_n = 1'b0, batteryGood = 1'b1;
	logic interruptsEnabled = 1'b0, wakePinDisable = 1'b0;
	logic haltRegRead = 1'b0, standbyRegRead = 1'b0;
	logic flagClearWrite = 1'b0, clockDividerWrite = 1'b0;
	logic busCycleDone, sdramSelfRefreshAck, oscillatorEnableOut, mainClockEnable;
	logic cpuClockEnable, pllReconfigure, sdramSelfRefreshReq, wokeFromStandbyFlag;
	logic powerFailFlag, userResetFlag, bootStart;
	logic [1:0] operatingState;
	int badCount = 0;
	int comparisons = 0;
	int waited, bootWait;
	int pllPulses = 0;
	int pllBase = 0;
	int bootPulses = 0;
	logic [31:0] lfsr = 32'h013a2153;

	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		if (pllReconfigure === 1'b1) pllPulses++;
		if (bootStart === 1'b1) bootPulses++;
	end

	psc_controller #(.TICK_DIV(TDIV), .BLACKOUT_TICKS(2), .IRQ_EXIT_TICKS(2),
		.PLL_LOCK_TICKS(2)) psc_controller_i (.clk, .reset_n, .wakePin, .powerFailIn_n,
		.userResetIn_n, .irq_n, .fiq_n, .lowBatteryIrq, .externalSupplyIndicator_n,
		.batteryGood, .interruptsEnabled, .wakePinDisable, .haltRegRead, .standbyRegRead,
		.flagClearWrite, .clockDividerWrite, .busCycleDone, .sdramSelfRefreshAck,
		.operatingState, .oscillatorEnableOut, .mainClockEnable, .cpuClockEnable,
		.pllReconfigure, .sdramSelfRefreshReq, .wokeFromStandbyFlag, .powerFailFlag,
		.userResetFlag, .bootStart);
	psc_core_model psc_core_model_i (.clk, .reset_n, .sdramSelfRefreshReq, .busCycleDone,
		.sdramSelfRefreshAck);

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
	endfunction
	// battery power with a bad battery is the one supply case that keeps standby
	function automatic logic [1:0] wake_target(input logic extN, input logic good);
		return (extN && !good) ? SB : RN;
	endfunction
	task automatic report_and_stop();
		if (badCount == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input logic [1:0] seen, input logic [1:0] expv);
		comparisons++;
		if (seen !== expv) begin
			badCount++;
			$display("FAIL at %0t: saw %b expected %b", $time, seen, expv);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask
	// bounded wait; a state never reached ends the run at once
	task automatic wait_state(input logic [1:0] expv, input int bound);
		waited = 0;
		while (operatingState !== expv && waited < bound) begin
			@(negedge clk);
			waited++;
		end
		check(operatingState, expv);
		if (operatingState !== expv) report_and_stop();
	endtask
	task automatic wake_edge();
		@(negedge clk);
		wakePin = 1'b1;
		idle(12);
		wakePin = 1'b0;
	endtask
	task automatic enter_halt();
		pulse(haltRegRead);
		wait_state(HT, 4);
	endtask
	task automatic read_standby();
		pulse(standbyRegRead);
		@(negedge clk);
		check(operatingState, SB);
		check(oscillatorEnableOut, 1'b0);
		check(sdramSelfRefreshReq, 1'b1);
		idle(5); // software keeps five idle slots after the read
	endtask

	initial begin
		idle(16);
		reset_n = 1'b1;
		check(operatingState, SB);
		check({mainClockEnable, cpuClockEnable}, 2'h0);
		check(sdramSelfRefreshReq, 1'b1);
		check({powerFailFlag, userResetFlag}, 2'h0);
		wakePin = 1'b1;
		idle(30);
		check(operatingState, SB);
		wakePin = 1'b0;
		idle(4);
		wake_edge();
		wait_state(RN, 60);
		check({oscillatorEnableOut, mainClockEnable}, 2'h3);
		check(cpuClockEnable, 1'b1);
		check(wokeFromStandbyFlag, 1'b1);
		for (bootWait = 0; bootWait < 1400 && bootPulses == 0; bootWait++) @(negedge clk);
		check(bootPulses == 1 && bootWait > 900, 1'b1);
		if (bootPulses == 0) report_and_stop();
		enter_halt();
		check({cpuClockEnable, oscillatorEnableOut}, 2'h1);
		check(wokeFromStandbyFlag, 1'b0);
		irq_n = 1'b0;
		idle(20);
		check(operatingState, HT);
		irq_n = 1'b1;
		interruptsEnabled = 1'b1;
		for (int k = 0; k < 6; k++) begin
			lfsr = lfsr_next(lfsr);
			enter_halt();
			idle(int'(lfsr[3:0]) + 2);
			if (lfsr[4]) irq_n = 1'b0;
			else fiq_n = 1'b0;
			wait_state(RN, 20);
			irq_n = 1'b1;
			fiq_n = 1'b1;
		end
		read_standby();
		pulse(haltRegRead);
		idle(4);
		check(operatingState, SB);
		wakePinDisable = 1'b1;
		idle(40);
		wake_edge();
		idle(30);
		check(operatingState, SB);
		wakePinDisable = 1'b0;
		irq_n = 1'b0;
		wait_state(RN, 100);
		check(waited >= TDIV, 1'b1);
		irq_n = 1'b1;
		pllBase = pllPulses;
		pulse(clockDividerWrite);
		wait_state(SB, 6);
		wait_state(RN, 100);
		check(pllPulses == pllBase + 1, 1'b1);
		for (int c = 0; c < 4; c++) begin
			read_standby();
			externalSupplyIndicator_n = c[1];
			batteryGood = c[0];
			idle(40);
			wake_edge();
			idle(40);
			check(operatingState, wake_target(c[1], c[0]));
			batteryGood = 1'b1;
			externalSupplyIndicator_n = 1'b0;
			idle(40);
			if (c == 2) wake_edge();
			wait_state(RN, 100);
		end
		enter_halt();
		batteryGood = 1'b0;
		lowBatteryIrq = 1'b1;
		idle(40);
		check(operatingState, HT);
		externalSupplyIndicator_n = 1'b1;
		wait_state(RN, 40);
		lowBatteryIrq = 1'b0;
		batteryGood = 1'b1;
		externalSupplyIndicator_n = 1'b0;
		idle(40);
		powerFailIn_n = 1'b0;
		wait_state(SB, 20);
		check(powerFailFlag, 1'b1);
		wake_edge();
		idle(20);
		check(operatingState, SB);
		powerFailIn_n = 1'b1;
		idle(40);
		wake_edge();
		wait_state(RN, 100);
		pulse(flagClearWrite);
		idle(2);
		check({powerFailFlag, wokeFromStandbyFlag}, 2'h0);
		enter_halt();
		userResetIn_n = 1'b0;
		wait_state(SB, 20);
		check(userResetFlag, 1'b1);
		userResetIn_n = 1'b1;
		idle(10);
		wake_edge();
		wait_state(RN, 100);
		// one-cycle user reset, then a wake edge that the hold must swallow
		userResetIn_n = 1'b0;
		@(negedge clk);
		userResetIn_n = 1'b1;
		wakePin = 1'b1;
		idle(20);
		check(operatingState, SB);
		wakePin = 1'b0;
		reset_n = 1'b0;
		idle(3);
		reset_n = 1'b1;
		check(operatingState, SB);
		check({oscillatorEnableOut, cpuClockEnable}, 2'h0);
		check({userResetFlag, wokeFromStandbyFlag}, 2'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
